/* dv/par_in_sva.sv */
// Purpose: link checker, source end facing port end
// Assumes: one ref_clk domain, rst_b async low
// Notes: latches land about 3 ref_clk after strobe rises
`timescale 1ns/1ps
`default_nettype none
module par_in_sva (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [23:0] data,
  input wire logic chan_sel,
  input wire logic strobe,
  input wire logic sample_clk,
  input wire par_in_pkg::sample_t chan_a,
  input wire par_in_pkg::sample_t chan_b,
  input wire logic pair_irq
);
  import par_in_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // latch and irq follow a strobe rise
  property p_ca; $rose(strobe) && !chan_sel |-> ##[3:5] chan_a == data; endproperty
  a_ca: assert property (p_ca) else $error("chan a missed");
  property p_cb; $rose(strobe) && chan_sel |-> ##[3:5] chan_b == data; endproperty
  a_cb: assert property (p_cb) else $error("chan b missed");
  property p_irq; $rose(strobe) && chan_sel |-> ##[3:5] pair_irq; endproperty
  a_irq: assert property (p_irq) else $error("irq missed");
  property p_one; $rose(pair_irq) |-> !$past(strobe, 7) && chan_sel; endproperty
  a_one: assert property (p_one) else $error("irq without b edge");
  // latches move only after a rise
  property p_ha; $changed(chan_a) |-> !chan_sel && strobe && !$past(strobe, 6); endproperty
  a_ha: assert property (p_ha) else $error("chan a moved");
  property p_hb; $changed(chan_b) |-> chan_sel && strobe && !$past(strobe, 6); endproperty
  a_hb: assert property (p_hb) else $error("chan b moved");
  // source side framing and port sample clock
  property p_sel; !strobe && !$past(strobe) |-> $stable(chan_sel); endproperty
  a_sel: assert property (p_sel) else $error("select moved");
  property p_sclk; $changed(sample_clk) |=> $stable(sample_clk)[*8]; endproperty
  a_sclk: assert property (p_sclk) else $error("sample clock glitch");
  c_a: cover property ($rose(strobe) && !chan_sel);
  c_b: cover property ($rose(pair_irq));
  c_s: cover property ($changed(sample_clk));
endmodule
`default_nettype wire

/* dv/tb.sv */
// Purpose: bench, source end driving port end
// Assumes: 25 ns ref_clk, reset 8 cycles
// Notes: xorshift pairs plus corner words
`timescale 1ns/1ps
`default_nettype none
module tb;
  import par_in_pkg::*;
  logic ref_clk = 0, rst_b = 0, pair_ack = 0, pair_valid = 0, single_chan = 0, pair_irq, pair_ready, sclk;
  sample_t word_a = 0, word_b = 0, chan_a, chan_b, exp_a = 0;
  logic [23:0] low_mask_b = 0;
  logic [31:0] seed = 32'h00DC877B;
  int fails = 0, cmp_count = 0, cyc = 0;
  par_in_if lk ();
  par_in_port par_in_port_inst (.ref_clk, .rst_b, .link(lk.port_end), .pair_ack, .chan_a, .chan_b,
    .pair_irq, .sample_clk_out(sclk));
  par_in_source par_in_source_inst (.ref_clk, .rst_b, .link(lk.source_end), .pair_valid, .single_chan,
    .word_a, .word_b, .low_mask_b, .pair_ready);
  par_in_sva par_in_sva_inst (.ref_clk, .rst_b, .data(lk.data), .chan_sel(lk.chan_sel), .strobe(lk.strobe),
    .sample_clk(lk.sample_clk), .chan_a, .chan_b, .pair_irq);
  // random source
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // word as a narrow source leaves it
  function automatic sample_t narrow(input sample_t w, input logic [23:0] m);
    return w & ~m;
  endfunction
  task automatic check(input string what, input logic [23:0] e, input logic [23:0] g);
    cmp_count++;
    if (e !== g) begin
      fails++;
      $display("BAD %s exp %h got %h", what, e, g);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // one pair request, pulsed for one cycle, then wait until the source is idle again
  task automatic send;
    pair_valid = 1;
    @(negedge ref_clk);
    pair_valid = 0;
    for (int n = 0; n < 200 && pair_ready !== 1'b1; n++) @(negedge ref_clk);
  endtask
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  // hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 4000) begin
      fails++;
      give_verdict;
    end
  end
  initial begin
    repeat (8) @(negedge ref_clk);
    rst_b = 1;
    check("idle", 3, {lk.chan_sel, lk.strobe});
    for (int i = 0; i < 14; i++) begin
      seed = xs(seed);
      low_mask_b = (24'h1 << (i < 2 ? 0 : seed[28:24] % 24)) - 24'h1;
      word_a = (i == 0) ? 24'h800000 : (i == 1) ? 24'hFFFFFF : seed[23:0];
      seed = xs(seed);
      word_b = (i == 0) ? 24'h7FFFFF : (i == 1) ? 24'h000001 : seed[23:0];
      word_a = narrow(word_a, low_mask_b);
      single_chan = (i % 4 == 3);
      if (!single_chan)
        exp_a = word_a;
      send;
      check("chan_a", exp_a, chan_a);
      check("chan_b", narrow(word_b, low_mask_b), chan_b);
      check("irq", 1, pair_irq);
      check("sclk", lk.sample_clk, sclk);
      pair_ack = 1;
      @(negedge ref_clk);
      pair_ack = 0;
      repeat (20) @(negedge ref_clk);
      check("irq_clear", 0, pair_irq);
    end
    give_verdict;
  end
endmodule
`default_nettype wire

/* rtl/par_in_defines.svh */
// Purpose: timing and width constants for the dual channel parallel sample input
// Assumes: ref_clk at 40 MHz
// Notes: included by bare name
`ifndef PAR_IN_DEFINES_SVH
`define PAR_IN_DEFINES_SVH
`define SAMPLE_WIDTH 24
`define SAMPLE_MSB 23
`define REF_CLK_MHZ 40
// sample clock output half period, in ref_clk cycles (full period is twice this)
`define SAMPLE_CLK_HALF 10'd416
// source side strobe half period in ref_clk cycles, less one
`define STROBE_HALF 8'd8
`endif

/* rtl/par_in_if.sv */
// Purpose: wires between sample source and capturing port
// Assumes: pull-ups on select and strobe modelled by the source end driving them high when idle
// Notes: no clocking block
`timescale 1ns/1ps
`default_nettype none
interface par_in_if;
  logic [23:0] data;
  logic chan_sel;
  logic strobe;
  logic sample_clk;
  modport port_end (input data, input chan_sel, input strobe, output sample_clk);
  modport source_end (output data, output chan_sel, output strobe, input sample_clk);
endinterface
`default_nettype wire

/* rtl/par_in_pkg.sv */
// Purpose: shared types for the parallel sample input
// Assumes: nothing
// Notes: types only
package par_in_pkg;
  typedef logic [23:0] sample_t;
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_SETUP = 4'b0010,
    S_LOW = 4'b0100,
    S_HIGH = 4'b1000
  } src_state_t;
endpackage

/* rtl/par_in_port.sv */
// Purpose: device end, captures strobed samples into channel latches
// Assumes: strobe and channel select come from outside the ref_clk domain
// Notes: data lines are held stable by the source around the strobe edge
// Notes: every link line passes two flops before any logic reads it
// Notes: data bits are synchronised one by one; they may skew by a cycle,
// Notes: which the source's settle time around the strobe edge absorbs
// Notes: latches and the pair interrupt land three ref_clk edges after the pin rises
// Notes: a new channel B capture wins over a pair acknowledge in the same cycle
// Notes: the sample clock runs free and is shared by both connectors
// Function
// - samples are 24-bit two's complement, two channels
// - 24 data lines, select, strobe; bit 23 MSB
// - capture only on rising strobe edge
// - select low stores into channel A
// - select high stores into channel B
// - channel B capture raises pair interrupt
// - source holds select while strobe low
// - source always delivers a channel B word
// - single channel source uses B only
// - narrow source left-justified, low bits zero
// - select and strobe default high
// - one shared sample clock output
`timescale 1ns/1ps
`default_nettype none
`include "par_in_defines.svh"
module par_in_port (
  input wire logic ref_clk,
  input wire logic rst_b,
  par_in_if.port_end link,
  input wire logic pair_ack,
  output var par_in_pkg::sample_t chan_a,
  output var par_in_pkg::sample_t chan_b,
  output var logic pair_irq,
  output var logic sample_clk_out
);
  import par_in_pkg::*;

  // select level to holding latch index, shared by capture and interrupt
  function automatic int chan_index(input logic sel);
    return sel ? 1 : 0;
  endfunction

  logic strobe_s;
  logic sel_s;
  logic strobe_d;
  logic [23:0] data_s;
  logic [9:0] clk_cnt;
  logic sclk;
  logic rise;
  logic take_b;
  sample_t hold [2];

  // synchronise strobe, reset high like the pull-up so no false edge follows
  sync2 #(
    .RESET_VAL(1'b1)
  ) u_strobe (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .din(link.strobe),
    .dout(strobe_s)
  );

  // synchronise select, idle high like the pull-up
  sync2 #(
    .RESET_VAL(1'b1)
  ) u_sel (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .din(link.chan_sel),
    .dout(sel_s)
  );

  // each data line through its own two stages, aligned with the strobe
  genvar bit_i;
  generate
    for (bit_i = 0; bit_i < `SAMPLE_WIDTH; bit_i++) begin : g_data_sync
      sync2 #(
        .RESET_VAL(1'b0)
      ) u_data (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .din(link.data[bit_i]),
        .dout(data_s[bit_i])
      );
    end
  endgenerate

  // edge detect on the synchronised strobe
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      strobe_d <= 1'b1;
    end else begin
      strobe_d <= strobe_s;
    end
  end
  assign rise = strobe_s & ~strobe_d;

  // two holding latches, written only on a rise, picked by the select level
  genvar ch_i;
  generate
    for (ch_i = 0; ch_i < 2; ch_i++) begin : g_latch
      always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          hold[ch_i] <= 24'h000000;
        end else if (rise && (chan_index(sel_s) == ch_i)) begin
          hold[ch_i] <= data_s;
        end
      end
    end
  endgenerate
  assign chan_a = hold[0];
  assign chan_b = hold[1];

  // a channel B capture marks a complete pair
  assign take_b = rise && (chan_index(sel_s) == 1);

  // pair interrupt, a new B capture wins over the acknowledge
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pair_irq <= 1'b0;
    end else if (take_b) begin
      pair_irq <= 1'b1;
    end else if (pair_ack) begin
      pair_irq <= 1'b0;
    end
  end

  // sample clock divider, one output for both connectors
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_cnt <= 10'h000;
      sclk <= 1'b0;
    end else if (clk_cnt == `SAMPLE_CLK_HALF - 10'd1) begin
      clk_cnt <= 10'h000;
      sclk <= ~sclk;
    end else begin
      clk_cnt <= clk_cnt + 10'd1;
    end
  end
  assign sample_clk_out = sclk;
  assign link.sample_clk = sclk;
endmodule
`default_nettype wire

/* rtl/par_in_source.sv */
// Purpose: source end, drives a sample pair with select and strobe
// Assumes: user presents a pair and holds it until accepted
// Notes: width given by low_mask_b, left-justified
`timescale 1ns/1ps
`default_nettype none
`include "par_in_defines.svh"
module par_in_source (
  input wire logic ref_clk,
  input wire logic rst_b,
  par_in_if.source_end link,
  input wire logic pair_valid,
  input wire logic single_chan,
  input wire par_in_pkg::sample_t word_a,
  input wire par_in_pkg::sample_t word_b,
  input wire logic [23:0] low_mask_b,
  output logic pair_ready
);
  import par_in_pkg::*;
  src_state_t state;
  logic [7:0] cnt;
  logic phase_b;
  logic [23:0] data_q;
  logic sel_q;
  logic strobe_q;
  logic [23:0] a_q;
  logic [23:0] b_q;
  logic single_q;

  // sequencer: setup with strobe high, then low, then rise
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= S_IDLE;
      cnt <= 8'h00;
      phase_b <= 1'b0;
      data_q <= 24'h000000;
      sel_q <= 1'b1;
      strobe_q <= 1'b1;
      a_q <= 24'h000000;
      b_q <= 24'h000000;
      single_q <= 1'b0;
    end else begin
      unique case (state)
        S_IDLE: begin
          strobe_q <= 1'b1;
          if (pair_valid) begin
            a_q <= word_a & ~low_mask_b;
            b_q <= word_b & ~low_mask_b;
            single_q <= single_chan;
            phase_b <= single_chan;
            state <= S_SETUP;
            cnt <= 8'h00;
          end
        end
        S_SETUP: begin
          data_q <= phase_b ? b_q : a_q;
          sel_q <= phase_b;
          if (cnt == `STROBE_HALF) begin
            cnt <= 8'h00;
            strobe_q <= 1'b0;
            state <= S_LOW;
          end else begin
            cnt <= cnt + 8'd1;
          end
        end
        S_LOW: begin
          if (cnt == `STROBE_HALF) begin
            cnt <= 8'h00;
            strobe_q <= 1'b1;
            state <= S_HIGH;
          end else begin
            cnt <= cnt + 8'd1;
          end
        end
        S_HIGH: begin
          if (cnt == `STROBE_HALF) begin
            cnt <= 8'h00;
            if (phase_b) begin
              state <= S_IDLE;
              sel_q <= 1'b1;
            end else begin
              phase_b <= 1'b1;
              state <= S_SETUP;
            end
          end else begin
            cnt <= cnt + 8'd1;
          end
        end
      endcase
    end
  end
  assign pair_ready = (state == S_IDLE);
  assign link.data = data_q;
  assign link.chan_sel = sel_q | single_q;
  assign link.strobe = strobe_q;
endmodule
`default_nettype wire

/* rtl/sync2.sv */
// Purpose: two flop synchroniser, one bit
// Assumes: async input
// Notes: first stage read only by second
`timescale 1ns/1ps
`default_nettype none
module sync2 #(parameter logic RESET_VAL = 1'b1) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic din,
  output logic dout
);
  logic meta;
  // two stages
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= RESET_VAL;
      dout <= RESET_VAL;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule
`default_nettype wire
